/* design/lvb_ctrl.sv */
// Digital control of the low-voltage buck: settings registers, mode
// selection, voltage change sequencing and the mode-change interrupt.
// Assumes an Avalon-MM master on mclk and static OTP straps on pins.
`timescale 1ns/1ns
`default_nettype none
module lvb_ctrl #(
    parameter int unsigned DISCH_CYCLES = lvb_pkg::DISCH_CYCLES_DEF
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        systemOn,
    input  wire logic        standbyState,
    input  wire logic        otpInPowerUpSeq,
    input  wire logic [4:0]  otpDefaultVoltageCode,
    input  wire logic [1:0]  otpInductorValueSelect,
    output logic      [4:0]  appliedVoltageCode,
    output logic      [12:0] setpointMv,
    output logic             regEnable,
    output logic             dischargeEn,
    output lvb_pkg::lvb_mode_e activeMode,
    output logic      [1:0]  currentLimitSelect,
    output logic      [2:0]  switchingPhaseSelect,
    output logic      [8:0]  phaseDeg,
    output logic      [1:0]  inductorValueSelect,
    output logic             irqOutN
);
    import lvb_pkg::*;

    localparam int CW = $clog2(DISCH_CYCLES + 1);
    localparam logic [CW-1:0] DISCH_LAST = CW'(DISCH_CYCLES - 1);

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    logic [9:0] pinRaw;
    logic [9:0] syncA, syncB;
    logic       sysOnS, stbyS, pupSeqS;
    logic [4:0] otpCodeS;
    logic [1:0] otpLselS;
    assign pinRaw = {systemOn, standbyState, otpInPowerUpSeq,
                     otpDefaultVoltageCode, otpInductorValueSelect};
    // Two flops on every pin; only the second stage is read.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            syncA <= 10'h000;
            syncB <= 10'h000;
        end
        else
        begin
            syncA <= pinRaw;
            syncB <= syncA;
        end
    end
    assign {sysOnS, stbyS, pupSeqS, otpCodeS, otpLselS} = syncB;
    // ------------------------------------------------------------------
    // Register file and bus slave
    // ------------------------------------------------------------------
    logic [1:0]  loadCnt, next_loadCnt;
    logic        loaded, next_loaded;
    logic [4:0]  outVoltageCode, next_outVoltageCode;
    lvb_mode_e   runMode, next_runMode;
    lvb_mode_e   stbyMode, next_stbyMode;
    logic [1:0]  curLim, next_curLim;
    logic [2:0]  phaseSel, next_phaseSel;
    logic [1:0]  lsel, next_lsel;
    logic        irqFlag, next_irqFlag;
    logic        irqMask, next_irqMask;
    logic        waitReq, next_waitReq;
    logic [31:0] rdData, next_rdData;
    logic        irqN, next_irqN;
    logic        wrEn, modeEvt;
    lvb_seq_e    seqState;

    // One wait state: a request is acknowledged in the cycle after it
    // appears and completes at the edge where waitrequest is seen low.
    always_comb
    begin
        next_loadCnt        = loadCnt;
        next_loaded         = loaded;
        next_outVoltageCode = outVoltageCode;
        next_runMode        = runMode;
        next_stbyMode       = stbyMode;
        next_curLim         = curLim;
        next_phaseSel       = phaseSel;
        next_lsel           = lsel;
        next_irqMask        = irqMask;
        next_waitReq        = 1'b1;
        next_rdData         = 32'h0000_0000;
        wrEn                = avs_write && !waitReq;
        // Straps are caught only after they cleared the synchroniser.
        if (!loaded)
        begin
            next_loadCnt = loadCnt + 2'h1;
            if (loadCnt == LOAD_DELAY)
            begin
                next_loaded         = 1'b1;
                next_outVoltageCode = otpCodeS;
                next_runMode  = pupSeqS ? LVB_AUTOSKIP : LVB_OFF;
                next_stbyMode = pupSeqS ? LVB_AUTOSKIP : LVB_OFF;
                next_lsel     = otpLselS;
            end
        end
        if (loaded && waitReq && (avs_read || avs_write))
        begin
            next_waitReq = 1'b0;
            if (avs_read)
            begin
                case (avs_address)
                    REG_VOLT:   next_rdData[4:0] = outVoltageCode;
                    REG_MODE:   next_rdData[3:0] = {stbyMode, runMode};
                    REG_CFG:    next_rdData[6:0] = {phaseSel, 2'h0, curLim};
                    REG_STATUS:
                    begin
                        next_rdData[1:0]  = activeMode;
                        next_rdData[ST_EN_BIT]  = regEnable;
                        next_rdData[ST_DIS_BIT] = dischargeEn;
                        next_rdData[5:4]  = seqState;
                        next_rdData[ST_LSEL_LSB +: 2] = lsel;
                        next_rdData[ST_MV_LSB +: 13]  = setpointMv;
                    end
                    REG_IRQ:    next_rdData[1:0] = {irqMask, irqFlag};
                    default:    next_rdData = 32'h0000_0000;
                endcase
            end
        end
        if (wrEn)
        begin
            case (avs_address)
                REG_VOLT: next_outVoltageCode = avs_writedata[4:0];
                REG_MODE:
                begin
                    next_runMode  =
                        lvb_mode_e'(avs_writedata[MODE_RUN_LSB +: 2]);
                    next_stbyMode =
                        lvb_mode_e'(avs_writedata[MODE_STBY_LSB +: 2]);
                end
                REG_CFG:
                begin
                    next_curLim   = avs_writedata[CFG_ILIM_LSB +: 2];
                    next_phaseSel = avs_writedata[CFG_PHASE_LSB +: 3];
                end
                REG_IRQ:  next_irqMask = avs_writedata[IRQ_MASK_BIT];
                default:  next_irqMask = irqMask;
            endcase
        end
        // A new mode event beats a clear in the same cycle.
        next_irqFlag = (irqFlag && !(wrEn && avs_address == REG_IRQ
                       && avs_writedata[IRQ_FLAG_BIT])) || modeEvt;
        next_irqN = !(next_irqFlag && !next_irqMask);
    end

    // Registers of the bus group.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            loadCnt        <= 2'h0;
            loaded         <= 1'b0;
            outVoltageCode <= VCODE_RST;
            runMode        <= LVB_OFF;
            stbyMode       <= LVB_OFF;
            curLim         <= ILIM_RST;
            phaseSel       <= PHASE_RST;
            lsel           <= 2'h0;
            irqFlag        <= 1'b0;
            irqMask        <= 1'b0;
            waitReq        <= 1'b1;
            rdData         <= 32'h0000_0000;
            irqN           <= 1'b1;
        end
        else
        begin
            loadCnt        <= next_loadCnt;
            loaded         <= next_loaded;
            outVoltageCode <= next_outVoltageCode;
            runMode        <= next_runMode;
            stbyMode       <= next_stbyMode;
            curLim         <= next_curLim;
            phaseSel       <= next_phaseSel;
            lsel           <= next_lsel;
            irqFlag        <= next_irqFlag;
            irqMask        <= next_irqMask;
            waitReq        <= next_waitReq;
            rdData         <= next_rdData;
            irqN           <= next_irqN;
        end
    end

    assign avs_waitrequest      = waitReq;
    assign avs_readdata         = rdData;
    assign irqOutN              = irqN;
    assign currentLimitSelect   = curLim;
    assign switchingPhaseSelect = phaseSel;
    assign inductorValueSelect  = lsel;

    // ------------------------------------------------------------------
    // Mode selection and voltage change sequencer
    // ------------------------------------------------------------------
    lvb_seq_e      next_seqState;
    logic [CW-1:0] dischCnt, next_dischCnt;
    logic [4:0]    next_appliedCode;
    lvb_mode_e     next_activeMode;
    logic          next_regEnable, next_dischargeEn;
    logic [12:0]   next_setpointMv;
    logic [8:0]    next_phaseDeg;

    lvb_setpoint_decode u_decode (
        .code       (next_appliedCode),
        .setpointMv (next_setpointMv)
    );
    // The code is only changed with the output dark, so the power stage
    // never slews between set points under load.
    always_comb
    begin
        next_seqState    = seqState;
        next_dischCnt    = dischCnt;
        next_appliedCode = appliedVoltageCode;
        next_activeMode  = (sysOnS && loaded)
                         ? (stbyS ? stbyMode : runMode) : LVB_OFF;
        modeEvt          = next_activeMode != activeMode;
        case (seqState)
            SEQ_IDLE:
            begin
                // Standby entry does not touch the code.
                if (outVoltageCode != appliedVoltageCode)
                begin
                    if (sysOnS && regEnable)
                    begin
                        next_seqState = SEQ_DISCH;
                        next_dischCnt = DISCH_LAST;
                    end
                    else
                    begin
                        next_appliedCode = outVoltageCode;
                    end
                end
            end
            SEQ_DISCH:
            begin
                next_dischCnt = dischCnt - CW'(1);
                if (dischCnt == '0)
                begin
                    next_seqState = SEQ_REEN;
                end
            end
            SEQ_REEN:
            begin
                next_appliedCode = outVoltageCode;
                next_seqState    = SEQ_IDLE;
            end
            default: next_seqState = SEQ_IDLE;
        endcase
        next_regEnable   = next_activeMode != LVB_OFF
                           && next_seqState == SEQ_IDLE;
        next_dischargeEn = !next_regEnable;
        next_phaseDeg    = (phaseSel == 3'h7) ? 9'h000
                         : 9'(({6'h00, phaseSel} + 9'h001) * 9'h02D);
    end

    // Registers of the sequencer group; code, set point, enable, discharge, mode and phase angle outputs come from here.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            seqState           <= SEQ_IDLE;
            dischCnt           <= '0;
            appliedVoltageCode <= VCODE_RST;
            activeMode         <= LVB_OFF;
            regEnable          <= 1'b0;
            dischargeEn        <= 1'b1;
            setpointMv         <= VMIN_MV;
            phaseDeg           <= 9'h000;
        end
        else
        begin
            seqState           <= next_seqState;
            dischCnt           <= next_dischCnt;
            appliedVoltageCode <= next_appliedCode;
            activeMode         <= next_activeMode;
            regEnable          <= next_regEnable;
            dischargeEn        <= next_dischargeEn;
            setpointMv         <= next_setpointMv;
            phaseDeg           <= next_phaseDeg;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_code_change_dark: assert property (
        seqState == SEQ_IDLE && outVoltageCode != appliedVoltageCode
        && sysOnS && regEnable |=> seqState == SEQ_DISCH && !regEnable
        && dischargeEn && $stable(appliedVoltageCode))
        else $error("code change while on did not discharge first");
    a_reen_new_code: assert property (
        seqState == SEQ_REEN |-> !regEnable ##1 (seqState == SEQ_IDLE
        && appliedVoltageCode == $past(outVoltageCode)))
        else $error("re-enable did not take the new code");
    a_clamp_top: assert property (
        appliedVoltageCode >= VCODE_CLAMP |-> setpointMv == VMAX_MV)
        else $error("high codes do not saturate");
    a_strap_load: assert property (
        !loaded && loadCnt == LOAD_DELAY |=> loaded
        && outVoltageCode == $past(otpCodeS)
        && runMode == ($past(pupSeqS) ? LVB_AUTOSKIP : LVB_OFF))
        else $error("power-up defaults not loaded");
    a_mode_select: assert property (
        loaded && sysOnS ##1 $stable(stbyS) && $stable(runMode)
        && $stable(stbyMode) |-> activeMode == (stbyS ? stbyMode : runMode))
        else $error("active mode not the current state's field");
    a_mode_irq: assert property (
        activeMode != $past(activeMode) |-> irqFlag && irqOutN == irqMask)
        else $error("mode change did not latch interrupt");
    a_flag_latched: assert property (
        irqFlag && !(wrEn && avs_address == REG_IRQ) |=> irqFlag)
        else $error("interrupt flag dropped without a clear");
    a_irq_gate: assert property (
        irqOutN == !(irqFlag && !irqMask))
        else $error("interrupt pin does not follow flag and mask");
    a_stby_volt: assert property (
        $rose(stbyS) && seqState == SEQ_IDLE
        && outVoltageCode == appliedVoltageCode |=> $stable(appliedVoltageCode))
        else $error("standby entry changed the voltage");
    a_phase_map: assert property (
        phaseSel == 3'h3 |=> phaseDeg == 9'h0B4)
        else $error("phase code 3 not 180 degrees");
    c_code_seq: cover property (seqState == SEQ_REEN);
    c_mode_irq: cover property (!irqOutN);
    c_stby_entry: cover property ($rose(stbyS) && regEnable);
endmodule : lvb_ctrl
`default_nettype wire

/* design/lvb_pkg.sv */
// Constants, field layouts and types of the low-voltage buck control block.
// Assumes a 100 MHz system clock and word-aligned Avalon-MM byte addresses.
//
// Contract
// - One 5-bit output voltage code serves both run and standby states.
// - Code 0 gives 1.00 V, non-uniform steps, codes 27 and up give 4.10 V.
// - Code change while on discharges first, then re-enables at new level.
// - At power-up the voltage code loads from the OTP default field.
// - Run mode field loads autoskip if in power-up sequence, else off.
// - Standby mode field loads autoskip if in power-up sequence, else off.
// - Modes 00 off, 01 PWM, 10 PFM, 11 autoskip; current state applies.
// - A mode change sets the mode-change flag; unmasked, irq goes low.
// - Run to standby keeps the output voltage unless enable state changes.
// - Two-bit current limit select: 2.1, 2.6, 3.0 or 4.5 A.
// - Three-bit phase field defaults to 0 degrees and is writable while on.
// - Phase codes 000..110 give 45..315 degrees, code 111 gives 0 degrees.
// - Two-bit OTP inductor select: 1.0, 0.47, 1.5 uH, code 11 reserved.
package lvb_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [4:0] REG_VOLT   = 5'h00;
    localparam logic [4:0] REG_MODE   = 5'h04;
    localparam logic [4:0] REG_CFG    = 5'h08;
    localparam logic [4:0] REG_STATUS = 5'h0C;
    localparam logic [4:0] REG_IRQ    = 5'h10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MODE_RUN_LSB  = 0;
    localparam int MODE_STBY_LSB = 2;
    localparam int CFG_ILIM_LSB  = 0;
    localparam int CFG_PHASE_LSB = 4;
    localparam int IRQ_FLAG_BIT  = 0;
    localparam int IRQ_MASK_BIT  = 1;
    localparam int ST_EN_BIT     = 2;
    localparam int ST_DIS_BIT    = 3;
    localparam int ST_LSEL_LSB   = 8;
    localparam int ST_MV_LSB     = 16;

    // ------------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LVB_OFF      = 2'h0,
        LVB_PWM      = 2'h1,
        LVB_PFM      = 2'h2,
        LVB_AUTOSKIP = 2'h3
    } lvb_mode_e;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'h0,
        SEQ_DISCH = 2'h1,
        SEQ_REEN  = 2'h3
    } lvb_seq_e;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [4:0] VCODE_RST   = 5'h00;
    localparam logic [4:0] VCODE_CLAMP = 5'h1B;
    localparam logic [12:0] VMAX_MV    = 13'h1004;
    localparam logic [12:0] VMIN_MV    = 13'h03E8;
    localparam logic [2:0] PHASE_RST   = 3'h7;
    localparam logic [1:0] ILIM_RST    = 2'h0;
    localparam logic [1:0] LOAD_DELAY  = 2'h2;
    localparam int CLK_MHZ             = 100;
    localparam int DISCH_TIME_US       = 200;
    localparam int DISCH_CYCLES_DEF    = DISCH_TIME_US * CLK_MHZ;

endpackage : lvb_pkg

/* design/lvb_setpoint_decode.sv */
// Voltage code to set point decoder, result in millivolts.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module lvb_setpoint_decode (
    input  wire logic [4:0]  code,
    output logic      [12:0] setpointMv
);
    import lvb_pkg::*;

    // Non-uniform table; everything from the clamp code up saturates.
    always_comb
    begin
        case (code)
            5'h00:   setpointMv = 13'h03E8;
            5'h01:   setpointMv = 13'h044C;
            5'h02:   setpointMv = 13'h04B0;
            5'h03:   setpointMv = 13'h04E2;
            5'h04:   setpointMv = 13'h0514;
            5'h05:   setpointMv = 13'h0546;
            5'h06:   setpointMv = 13'h05DC;
            5'h07:   setpointMv = 13'h0640;
            5'h08:   setpointMv = 13'h0708;
            5'h09:   setpointMv = 13'h073A;
            5'h0A:   setpointMv = 13'h07D0;
            5'h0B:   setpointMv = 13'h0834;
            5'h0C:   setpointMv = 13'h0866;
            5'h0D:   setpointMv = 13'h08CA;
            5'h0E:   setpointMv = 13'h08FC;
            5'h0F:   setpointMv = 13'h0960;
            5'h10:   setpointMv = 13'h09C4;
            5'h11:   setpointMv = 13'h0AF0;
            5'h12:   setpointMv = 13'h0C4E;
            5'h13:   setpointMv = 13'h0C80;
            5'h14:   setpointMv = 13'h0CB2;
            5'h15:   setpointMv = 13'h0CE4;
            5'h16:   setpointMv = 13'h0D16;
            5'h17:   setpointMv = 13'h0D48;
            5'h18:   setpointMv = 13'h0DAC;
            5'h19:   setpointMv = 13'h0ED8;
            5'h1A:   setpointMv = 13'h0FA0;
            default: setpointMv = VMAX_MV;
        endcase
    end

endmodule : lvb_setpoint_decode
`default_nettype wire

/* sim/lvb_host_model.sv */
// Host bus master model: single Avalon-MM reads and writes on mclk.
// Assumes callers sit in one process and the bench owns the timeout.
`timescale 1ns/1ns
`default_nettype none
module lvb_host_model (
    input  wire logic        mclk,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    output logic      [4:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata
);
    // Idle bus at time zero; data shows a non-zero pattern until the first write.
    initial
    begin
        avs_address   = 5'h1F;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'hA5A5A5A5;
    end

    // Request is held until waitrequest is sampled low; no cycle count
    // is assumed, so a stuck slave is caught only by the bench watchdog.
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do
            @(posedge mclk);
        while (avs_waitrequest !== 1'b0);
        avs_write     <= 1'b0;
        avs_writedata <= ~d;
    endtask : wr

    // Read data is taken at the same edge that sees waitrequest low.
    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        @(posedge mclk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do
            @(posedge mclk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read    <= 1'b0;
        avs_address <= ~a;
    endtask : rd
endmodule : lvb_host_model
`default_nettype wire

/* sim/buck_regulator_digital_control_tb.sv */
// Self-checking bench of the buck control block: pins and straps are
// driven here, registers are reached through the host model.
`timescale 1ns/1ns
`default_nettype none
module buck_regulator_digital_control_tb;
    import lvb_pkg::*;
    localparam int unsigned DISCH = 8;
    logic        mclk;
    logic        rst   = 1'b1;
    logic        sysOn = 1'b1;
    logic        stby  = 1'b0;
    logic        pupSeq = 1'b1;
    logic [4:0]  otpCode = 5'h0A;
    logic [4:0]  addr, volt;
    logic        rd, wr, wreq, regEn, disEn, irqN;
    logic [31:0] wdata, rdata, val;
    logic [12:0] spMv;
    lvb_mode_e   mode;
    logic [1:0]  ilim, lsel;
    logic [2:0]  phSel;
    logic [8:0]  phDeg;
    int          miscompares = 0;
    int          checked = 0;
    int          n;
    // Set points in mV for codes 0 to 26; higher codes clamp.
    logic [12:0] mvTab [27] = '{13'h3E8, 13'h44C, 13'h4B0, 13'h4E2,
        13'h514, 13'h546, 13'h5DC, 13'h640, 13'h708, 13'h73A, 13'h7D0,
        13'h834, 13'h866, 13'h8CA, 13'h8FC, 13'h960, 13'h9C4, 13'hAF0,
        13'hC4E, 13'hC80, 13'hCB2, 13'hCE4, 13'hD16, 13'hD48, 13'hDAC,
        13'hED8, 13'hFA0};

    lvb_ctrl #(.DISCH_CYCLES(DISCH)) uut (
        .mclk(mclk), .rst(rst), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .systemOn(sysOn), .standbyState(stby),
        .otpInPowerUpSeq(pupSeq), .otpDefaultVoltageCode(otpCode),
        .otpInductorValueSelect(2'h2), .appliedVoltageCode(volt),
        .setpointMv(spMv), .regEnable(regEn), .dischargeEn(disEn),
        .activeMode(mode), .currentLimitSelect(ilim),
        .switchingPhaseSelect(phSel), .phaseDeg(phDeg),
        .inductorValueSelect(lsel), .irqOutN(irqN));

    lvb_host_model host (.mclk(mclk), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Pins pass two flops plus a register, so six edges always settle.
    task automatic settle;
        repeat (6) @(posedge mclk);
    endtask : settle

    // Bounded wait on the enable, so a stuck sequencer cannot hang us.
    task automatic waitEn(input logic lvl);
        n = 0;
        while (regEn !== lvl && n < 200)
        begin
            @(posedge mclk);
            n++;
        end
    endtask : waitEn

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Tests need about 500 cycles; the watchdog allows 50000.
    initial
    begin
        #500000;
        miscompares++;
        print_verdict();
    end

    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge mclk);
        chk("irqOutN in reset", 32'h1, irqN);
        rst <= 1'b0;
        settle();
        chk("run mode at load", LVB_AUTOSKIP, mode);
        chk("inductor", 32'h2, lsel);
        chk("code at load", 32'h0A, volt);
        chk("irqOutN at load", 32'h0, irqN);
        host.rd(REG_MODE, val);
        chk("mode reg", 32'hF, val);
        host.rd(REG_CFG, val);
        chk("cfg reg", 32'h70, val);
        host.wr(REG_IRQ, 32'h1);
        settle();
        chk("irqOutN cleared", 32'h1, irqN);
        for (int m = 0; m < 4; m++)
        begin
            host.wr(REG_MODE, 32'(m) | 32'hC);
            settle();
            chk("active mode", 32'(m), mode);
            chk("irqOutN change", 32'h0, irqN);
            host.wr(REG_IRQ, 32'h1);
        end
        // Masked change keeps the pin high yet the flag still latches.
        host.wr(REG_IRQ, 32'h3);
        host.wr(REG_MODE, 32'hD);
        settle();
        chk("irqOutN masked", 32'h1, irqN);
        host.rd(REG_IRQ, val);
        chk("flag masked", 32'h3, val);
        host.wr(REG_IRQ, 32'h1);
        host.wr(REG_MODE, 32'h9);
        stby <= 1'b1;
        settle();
        chk("standby mode", LVB_PFM, mode);
        chk("standby code", 32'h0A, volt);
        chk("standby enable", 32'h1, regEn);
        stby <= 1'b0;
        settle();
        host.wr(REG_VOLT, 32'h1B);
        waitEn(1'b0);
        chk("discharging", 32'h1, disEn);
        chk("old code held", 32'h0A, volt);
        waitEn(1'b1);
        chk("discharge span", 32'h1, n >= DISCH && n <= DISCH + 3);
        chk("new code", 32'h1B, volt);
        chk("new set point", VMAX_MV, spMv);
        host.rd(REG_STATUS, val);
        chk("status", 32'h1004_0205, val);
        // With the regulator off every code is applied at once.
        host.wr(REG_MODE, 32'h0);
        for (int i = 0; i < 32; i++)
        begin
            host.wr(REG_VOLT, 32'(i));
            settle();
            chk("code", 32'(i), volt);
            chk("set point", i > 26 ? VMAX_MV : mvTab[i], spMv);
        end
        for (int p = 0; p < 8; p++)
        begin
            host.wr(REG_CFG, (32'(p) << 4) | 32'(p & 3));
            settle();
            chk("phase code", 32'(p), phSel);
            chk("phase deg", p == 7 ? 0 : 45 * (p + 1), phDeg);
            chk("current limit", 32'(p & 3), ilim);
        end
        host.wr(5'h14, 32'hFFFFFFFF);
        host.rd(5'h14, val);
        chk("unmapped", 32'h0, val);
        host.wr(REG_MODE, 32'hF);
        sysOn <= 1'b0;
        settle();
        chk("system off", LVB_OFF, mode);
        // Second power-up with the regulator left out of the sequence.
        rst <= 1'b1;
        pupSeq <= 1'b0;
        otpCode <= 5'h15;
        @(posedge mclk);
        rst <= 1'b0;
        settle();
        chk("code after reset", 32'h15, volt);
        chk("set point after reset", mvTab[21], spMv);
        chk("phase after reset", 32'h7, phSel);
        host.rd(REG_MODE, val);
        chk("modes left out", 32'h0, val);
        print_verdict();
    end
endmodule : buck_regulator_digital_control_tb
`default_nettype wire
